// file: scg_glitchless_gate.sv
`timescale 1ns/100ps
// ------------------------------------------------------------------
// glitch-free clock gate: enable registered on the falling clock edge
// ------------------------------------------------------------------
module scg_glitchless_gate (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_en,
  output logic      o_gclk,
  output logic      o_en
);

  logic en_q;

  // enable changes only on falling edge or at async reset, so outside reset the high phase is never cut
  always_ff @(negedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      en_q <= 1'b0;
    end else begin
      en_q <= i_en;
    end
  end

  assign o_gclk = i_clk & en_q;
  assign o_en   = en_q;

endmodule : scg_glitchless_gate

// file: scg_pkg.sv
package scg_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [11:0] SLEEP_GATE_OFF   = 12'h110;
  localparam logic [11:0] IRQ_STATUS_OFF   = 12'h114;
  localparam logic [11:0] IRQ_MASK_OFF     = 12'h118;
  localparam logic [11:0] GATE_STATE_OFF   = 12'h11C;
  localparam logic [11:0] CONTROL_OFF      = 12'h120;

  localparam logic [31:0] SLEEP_GATE_RST   = 32'h00000040;
  localparam logic [31:0] SLEEP_GATE_WMASK = 32'h03010348;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int CAN_UNIT_ONE_GATE_BIT  = 25;
  localparam int CAN_UNIT_ZERO_GATE_BIT  = 24;
  localparam int CONV_BIT  = 16;
  localparam int RATE_LSB  = 8;
  localparam int HIB_BIT   = 6;
  localparam int WDT_BIT   = 3;
  localparam int NUM_UNITS = 5;

  // unit index order in the gate vector
  localparam int U_WDT  = 0;
  localparam int U_HIB  = 1;
  localparam int U_CONV = 2;
  localparam int U_CAN_UNIT_ZERO_GATE = 3;
  localparam int U_CAN_UNIT_ONE_GATE = 4;

  // interrupt status bits
  localparam int IRQ_FAULT_BIT = 0;
  localparam int IRQ_ENTER_BIT = 1;
  localparam int IRQ_LEAVE_BIT = 2;
  localparam int IRQ_W         = 3;

  // control register bits
  localparam int CTL_AUTO_BIT  = 0;
  localparam int CTL_SLEEP_BIT = 1;

  // converter rates
  localparam logic [1:0] RATE_125K = 2'h0;
  localparam logic [1:0] RATE_250K = 2'h1;
  localparam logic [1:0] RATE_500K = 2'h2;
  localparam logic [1:0] RATE_1M   = 2'h3;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } scg_bus_s;

  typedef struct packed {
    logic [11:0] addr;
    logic        wr;
    logic        rd;
    logic [2:0]  unit;
  } scg_unit_acc_s;

endpackage : scg_pkg

// file: scg_sleep_gate.sv
`timescale 1ns/100ps
module scg_sleep_gate (
  input  wire logic                   I_MCLK,
  input  wire logic                   I_RSTN,
  input  wire logic [11:0]            I_ADDR,
  input  wire logic [31:0]            I_WDATA,
  input  wire logic                   I_WR,
  input  wire logic                   I_RD,
  output logic [31:0]                 O_RDATA,
  input  wire logic [31:0]            I_RUN_GATE,
  input  wire logic [31:0]            I_DEEP_SLEEP_GATE,
  input  wire logic                   I_DEEP_SLEEP,
  input  wire logic                   I_UNIT_WR,
  input  wire logic                   I_UNIT_RD,
  input  wire logic [2:0]             I_UNIT_SEL,
  output logic                        O_BUS_FAULT,
  output logic [scg_pkg::NUM_UNITS-1:0] O_UNIT_CLK,
  output logic [scg_pkg::NUM_UNITS-1:0] O_UNIT_EN,
  output logic [1:0]                  O_RATE_SEL,
  output logic                        O_AUTO_GATE_SELECT,
  output logic                        O_IRQ
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [scg_pkg::NUM_UNITS-1:0] unit_bits(input logic [31:0] r);
    unit_bits = {r[scg_pkg::CAN_UNIT_ONE_GATE_BIT], r[scg_pkg::CAN_UNIT_ZERO_GATE_BIT], r[scg_pkg::CONV_BIT],
                 r[scg_pkg::HIB_BIT], r[scg_pkg::WDT_BIT]};
  endfunction : unit_bits

  scg_pkg::scg_bus_s      bus;
  scg_pkg::scg_unit_acc_s uacc;

  assign bus  = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};
  assign uacc = '{addr: 12'h000, wr: I_UNIT_WR, rd: I_UNIT_RD, unit: I_UNIT_SEL};

  logic [31:0]              sleep_gate_reg_q;
  logic [scg_pkg::IRQ_W-1:0] irq_status_q;
  logic [scg_pkg::IRQ_W-1:0] irq_mask_q;
  logic                     auto_gate_select_q;
  logic                     sleep_req_q;
  logic                     sleep_act_q;
  logic                     fault_q;
  logic [31:0]              rdata_q;
  logic [scg_pkg::NUM_UNITS-1:0] sel_en;
  logic [scg_pkg::NUM_UNITS-1:0] unit_en_live;
  logic                     fault_ev;
  logic                     in_sleep;
  logic                     enter_ev;
  logic                     leave_ev;

  // ------------------------------------------------------------------
  // sleep gate register
  // ------------------------------------------------------------------
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      sleep_gate_reg_q <= scg_pkg::SLEEP_GATE_RST;
    end else if (bus.wr && bus.addr == scg_pkg::SLEEP_GATE_OFF) begin
      // enable and rate bits are written, reserved bits stay zero
      sleep_gate_reg_q <= bus.wdata & scg_pkg::SLEEP_GATE_WMASK;
    end
  end

  // ------------------------------------------------------------------
  // control: auto gate select and sleep request
  // ------------------------------------------------------------------
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      auto_gate_select_q <= 1'b0;
      sleep_req_q        <= 1'b0;
    end else if (bus.wr && bus.addr == scg_pkg::CONTROL_OFF) begin
      auto_gate_select_q <= bus.wdata[scg_pkg::CTL_AUTO_BIT];
      sleep_req_q        <= bus.wdata[scg_pkg::CTL_SLEEP_BIT];
    end
  end

  assign in_sleep = sleep_req_q & auto_gate_select_q;

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      sleep_act_q <= 1'b0;
    end else begin
      sleep_act_q <= in_sleep;
    end
  end

  assign enter_ev = in_sleep & ~sleep_act_q;
  assign leave_ev = ~in_sleep & sleep_act_q;

  // ------------------------------------------------------------------
  // enable selection by operating mode
  // ------------------------------------------------------------------
  always_comb begin
    if (!auto_gate_select_q) begin
      sel_en = unit_bits(I_RUN_GATE);
    end else if (sleep_act_q && I_DEEP_SLEEP) begin
      sel_en = unit_bits(I_DEEP_SLEEP_GATE);
    end else if (sleep_act_q) begin
      sel_en = unit_bits(sleep_gate_reg_q);
    end else begin
      sel_en = unit_bits(I_RUN_GATE);
    end
  end

  // ------------------------------------------------------------------
  // per-unit clock gates
  // ------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < scg_pkg::NUM_UNITS; gi++) begin : g_gate
      scg_glitchless_gate u_gate (
        .i_clk  (I_MCLK),
        .i_rstn (I_RSTN),
        .i_en   (sel_en[gi]),
        .o_gclk (O_UNIT_CLK[gi]),
        .o_en   (unit_en_live[gi])
      );
    end
  endgenerate

  assign O_UNIT_EN = unit_en_live;

  // ------------------------------------------------------------------
  // bus fault on access to an unclocked unit
  // ------------------------------------------------------------------
  assign fault_ev = (uacc.wr | uacc.rd) &&
                    ((uacc.unit >= 3'(scg_pkg::NUM_UNITS)) || !unit_en_live[uacc.unit]);

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_ev;
    end
  end

  assign O_BUS_FAULT = fault_q;

  // ------------------------------------------------------------------
  // interrupts: sticky status, write one to clear, set wins
  // ------------------------------------------------------------------
  logic [scg_pkg::IRQ_W-1:0] irq_set;
  logic [scg_pkg::IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_set = '0;
    irq_set[scg_pkg::IRQ_FAULT_BIT] = fault_ev;
    irq_set[scg_pkg::IRQ_ENTER_BIT] = enter_ev;
    irq_set[scg_pkg::IRQ_LEAVE_BIT] = leave_ev;
    irq_clr = (bus.wr && bus.addr == scg_pkg::IRQ_STATUS_OFF) ?
              bus.wdata[scg_pkg::IRQ_W-1:0] : '0;
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      irq_status_q <= '0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      irq_mask_q <= '0;
    end else if (bus.wr && bus.addr == scg_pkg::IRQ_MASK_OFF) begin
      irq_mask_q <= bus.wdata[scg_pkg::IRQ_W-1:0];
    end
  end

  assign O_IRQ = |(irq_status_q & irq_mask_q);

  // ------------------------------------------------------------------
  // read data, one cycle after the strobe
  // ------------------------------------------------------------------
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rdata_q <= '0;
    end else if (bus.rd) begin
      case (bus.addr)
        scg_pkg::SLEEP_GATE_OFF: rdata_q <= sleep_gate_reg_q;
        scg_pkg::IRQ_STATUS_OFF: rdata_q <= {29'h0, irq_status_q};
        scg_pkg::IRQ_MASK_OFF:   rdata_q <= {29'h0, irq_mask_q};
        scg_pkg::GATE_STATE_OFF: rdata_q <= {26'h0, sleep_act_q, unit_en_live};
        scg_pkg::CONTROL_OFF:    rdata_q <= {30'h0, sleep_req_q, auto_gate_select_q};
        default:                 rdata_q <= 32'h00000000;
      endcase
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  assign O_RDATA            = rdata_q;
  assign O_RATE_SEL         = sleep_gate_reg_q[scg_pkg::RATE_LSB +: 2];
  assign O_AUTO_GATE_SELECT = auto_gate_select_q;

endmodule : scg_sleep_gate

// file: scg_sleep_gate_checker.sv
`timescale 1ns/100ps
module scg_sleep_gate_checker (
  input wire logic                         I_MCLK,
  input wire logic                         I_RSTN,
  input wire logic [11:0]                  I_ADDR,
  input wire logic [31:0]                  I_WDATA,
  input wire logic                         I_WR,
  input wire logic                         I_RD,
  input wire logic [31:0]                  O_RDATA,
  input wire logic [31:0]                  I_RUN_GATE,
  input wire logic                         I_UNIT_WR,
  input wire logic                         I_UNIT_RD,
  input wire logic [2:0]                   I_UNIT_SEL,
  input wire logic                         O_BUS_FAULT,
  input wire logic [scg_pkg::NUM_UNITS-1:0] O_UNIT_CLK,
  input wire logic [scg_pkg::NUM_UNITS-1:0] O_UNIT_EN,
  input wire logic [1:0]                   O_RATE_SEL,
  input wire logic                         O_AUTO_GATE_SELECT
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RSTN);
  logic acc;
  assign acc = I_UNIT_WR || I_UNIT_RD;
  rd_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 32'h0) else $error("read data not idle");
  rsvd_zero_a: assert property ($past(I_RD) && $past(I_ADDR) == scg_pkg::SLEEP_GATE_OFF
    |-> (O_RDATA & ~scg_pkg::SLEEP_GATE_WMASK) == 32'h0) else $error("reserved bit set");
  rate_wr_a: assert property (I_WR && I_ADDR == scg_pkg::SLEEP_GATE_OFF
    |=> O_RATE_SEL == $past(I_WDATA[9:8])) else $error("rate not written");
  fault_sel_a: assert property (acc && I_UNIT_SEL > 3'h4 |=> O_BUS_FAULT) else $error("no fault");
  fault_off_a: assert property (acc && I_UNIT_SEL < 3'h5 && !O_UNIT_EN[I_UNIT_SEL] |=> O_BUS_FAULT)
    else $error("no fault on gated unit");
  fault_on_a: assert property (acc && I_UNIT_SEL < 3'h5 && O_UNIT_EN[I_UNIT_SEL] |=> !O_BUS_FAULT)
    else $error("fault on clocked unit");
  fault_idle_a: assert property (!acc |=> !O_BUS_FAULT) else $error("stray fault");
  run_en_a: assert property ($past(I_RSTN) && !O_AUTO_GATE_SELECT && !$past(O_AUTO_GATE_SELECT, 2)
    |-> O_UNIT_EN == {I_RUN_GATE[25], I_RUN_GATE[24], I_RUN_GATE[16], I_RUN_GATE[6], I_RUN_GATE[3]})
    else $error("run enables not applied");
  gclk_en_a: assert property (@(negedge I_MCLK) disable iff (!I_RSTN) O_UNIT_CLK == O_UNIT_EN)
    else $error("gated clock mismatch");
  cover property (O_BUS_FAULT);
  cover property (O_AUTO_GATE_SELECT);
  cover property (O_RATE_SEL == 2'h3);
  cover property (O_UNIT_EN == 5'h1E);
endmodule : scg_sleep_gate_checker

bind scg_sleep_gate scg_sleep_gate_checker i_scg_sleep_gate_checker (.I_MCLK(I_MCLK), .I_RSTN(I_RSTN),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_RUN_GATE(I_RUN_GATE),
  .I_UNIT_WR(I_UNIT_WR), .I_UNIT_RD(I_UNIT_RD), .I_UNIT_SEL(I_UNIT_SEL), .O_BUS_FAULT(O_BUS_FAULT),
  .O_UNIT_CLK(O_UNIT_CLK), .O_UNIT_EN(O_UNIT_EN), .O_RATE_SEL(O_RATE_SEL),
  .O_AUTO_GATE_SELECT(O_AUTO_GATE_SELECT));

// file: tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [11:0] addr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [31:0] rgate = 32'h00000008;
  logic [31:0] dgate = 32'h0;
  logic        deep = 1'b0;
  logic        uwr = 1'b0;
  logic        urd = 1'b0;
  logic [2:0]  usel = 3'h0;
  logic        fault;
  logic [4:0]  uclk;
  logic [4:0]  uen;
  logic [1:0]  rate;
  logic        auto_sel;
  logic        irq;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          cyc = 0;
  logic [63:0] rows [5] = '{64'hFFFFFFFF_03010348, 64'h00000000_00000000, 64'h00000100_00000100,
                            64'h00000200_00000200, 64'h00000300_00000300};
  scg_sleep_gate i_scg_sleep_gate (.I_MCLK(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_RUN_GATE(rgate), .I_DEEP_SLEEP_GATE(dgate), .I_DEEP_SLEEP(deep),
    .I_UNIT_WR(uwr), .I_UNIT_RD(urd), .I_UNIT_SEL(usel), .O_BUS_FAULT(fault), .O_UNIT_CLK(uclk),
    .O_UNIT_EN(uen), .O_RATE_SEL(rate), .O_AUTO_GATE_SELECT(auto_sel), .O_IRQ(irq));
  initial begin
    forever #2 clk = ~clk;
  end
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task wrt(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrt
  task rdc(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask : rdc
  task acc(input logic [2:0] s, input logic w, input logic e);
    @(posedge clk);
    usel <= s;
    uwr <= w;
    urd <= ~w;
    @(posedge clk);
    uwr <= 1'b0;
    urd <= 1'b0;
    #1 `CHK(fault, e)
  endtask : acc
  task rst;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rdc(scg_pkg::SLEEP_GATE_OFF, scg_pkg::SLEEP_GATE_RST);
    `CHK(rate, 2'h0)
  endtask : rst
  initial begin
    rst();
    rdc(12'h000, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wrt(scg_pkg::SLEEP_GATE_OFF, rows[i][63:32]);
      rdc(scg_pkg::SLEEP_GATE_OFF, rows[i][31:0]);
      `CHK(rate, rows[i][9:8])
    end
    $display("register rows done");
    `CHK(uen, 5'h01)
    acc(3'h0, 1'b1, 1'b0);
    acc(3'h2, 1'b0, 1'b1);
    acc(3'h5, 1'b1, 1'b1);
    $display("fault test done");
    wrt(scg_pkg::SLEEP_GATE_OFF, 32'h03010040);
    wrt(scg_pkg::CONTROL_OFF, 32'h3);
    repeat (3) @(posedge clk);
    #1 `CHK(uen, 5'h1E)
    `CHK(uclk, 5'h1E)
    `CHK(auto_sel, 1'b1)
    rdc(scg_pkg::GATE_STATE_OFF, 32'h3E);
    acc(3'h0, 1'b0, 1'b1);
    @(posedge clk);
    deep <= 1'b1;
    dgate <= 32'h00000008;
    repeat (3) @(posedge clk);
    #1 `CHK(uen, 5'h01)
    @(posedge clk);
    deep <= 1'b0;
    wrt(scg_pkg::CONTROL_OFF, 32'h2);
    repeat (4) @(posedge clk);
    #1 `CHK(uen, 5'h01)
    $display("sleep test done");
    wrt(scg_pkg::IRQ_STATUS_OFF, 32'h7);
    acc(3'h4, 1'b0, 1'b1);
    #1 `CHK(irq, 1'b0)
    wrt(scg_pkg::IRQ_MASK_OFF, 32'h1);
    #1 `CHK(irq, 1'b1)
    rdc(scg_pkg::IRQ_STATUS_OFF, 32'h1);
    wrt(scg_pkg::IRQ_STATUS_OFF, 32'h1);
    #1 `CHK(irq, 1'b0)
    $display("irq test done");
    @(posedge clk);
    rgate <= 32'h01000040;
    repeat (2) @(posedge clk);
    #1 `CHK(uen, 5'h0A)
    `CHK(uclk, 5'h0A)
    $display("run gate test done");
    rst();
    $display("reset test done");
    end_sim();
  end
endmodule : tb
